//--- hdl/ecm_config_mapper.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Words 94h, 96h: slot capability low, ports 2-3.
// - Words 9Ah-9Eh: slot capability high, ports 1-3.
// - Words A0h-A6h bits 6:0: VC1 time slot.
// - Same words bits 15:8: class to VC1 map.
// - Words B0h-B6h: misc control 0 low word.
// - Words B8h-BEh: misc control 0 high word.
// - Word C0h: misc control 1 low, port 0.
// - Word 92h: slot capability low, port 1.
module ecm_config_mapper (
    // Clock and reset.
    input  wire logic                             clk_sys_i,
    input  wire logic                             rst_b_i,
    // Words from the memory read engine.
    input  wire logic                             word_valid_i,
    input  wire ecm_pkg::ecm_word_s               word_i,
    input  wire logic                             mem_present_i,
    input  wire logic                             load_done_i,
    // Register port.
    input  wire logic [13:0]                      addr_i,
    input  wire logic [31:0]                      wdata_i,
    input  wire logic                             wr_i,
    input  wire logic                             rd_i,
    output logic [31:0]                           rdata_o,
    // Configuration towards the ports.
    output ecm_pkg::ecm_port_cfg_s [ecm_pkg::NPORT-1:0] port_cfg_o,
    output logic                                  cfg_ready_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Local state.
    ////////////////////////////////////////////////////////////////////////////

    // Load finished; software may now use the registers.
    logic                cfg_ready;
    // Sticky flag for a word the engine failed to read.
    logic                word_err;
    // Memory presence, caught while loading.
    logic                mem_seen;
    // Software write protect for the port fields.
    logic                wr_prot;
    // Target of the current memory word.
    ecm_pkg::ecm_tgt_s   tgt;
    // Word is taken into a field this cycle.
    logic                ld_take;
    // Port and field of the bus access.
    logic [1:0]          bus_port;
    ecm_pkg::ecm_fld_e   bus_fld;
    // Port-space offset of the bus access.
    logic [11:0]         bus_off;
    // Bus write that reaches a port field.
    logic                bus_fld_we;
    // Value to be returned for a read.
    logic [31:0]         next_rdata;

    // Every check below runs on the system clock and sleeps while reset is low.
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    assign cfg_ready_o = cfg_ready;
    assign bus_port    = addr_i[13:12];
    assign bus_off     = addr_i[11:0];

    ////////////////////////////////////////////////////////////////////////////
    // Offset decode, shared by writes and reads.
    ////////////////////////////////////////////////////////////////////////////

    // Turns a port-space offset into the field it names.
    function automatic ecm_pkg::ecm_fld_e off2fld(input logic [11:0] off);
        case (off)
            ecm_pkg::OFF_SLOT:  off2fld = ecm_pkg::FLD_SLOT;
            ecm_pkg::OFF_VCTS:  off2fld = ecm_pkg::FLD_VCTS;
            ecm_pkg::OFF_TCVC:  off2fld = ecm_pkg::FLD_TCVC;
            ecm_pkg::OFF_MISC0: off2fld = ecm_pkg::FLD_MISC0;
            ecm_pkg::OFF_MISC1: off2fld = ecm_pkg::FLD_MISC1;
            default:            off2fld = ecm_pkg::FLD_NONE;
        endcase
    endfunction : off2fld

    assign bus_fld = off2fld(bus_off);

    ////////////////////////////////////////////////////////////////////////////
    // Memory word path.
    ////////////////////////////////////////////////////////////////////////////

    // Address decode of the incoming word.
    ecm_word_decode u_decode (
        .addr_i (word_i.addr),
        .tgt_o  (tgt)
    );

    // A word lands only if memory is there, the read was good and the
    // load phase is still open. A bad read leaves the default in place.
    assign ld_take = word_valid_i && mem_present_i && word_i.ok && !cfg_ready && tgt.hit;

    // Software is locked out until the load ends, so the two writers
    // never race for one field.
    assign bus_fld_we = wr_i && cfg_ready && !wr_prot && (bus_fld != ecm_pkg::FLD_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // Per-port field banks.
    ////////////////////////////////////////////////////////////////////////////

    for (genvar p = 0; p < ecm_pkg::NPORT; p++) begin : g_port
        // Each bank sees writes meant for its own port only.
        ecm_port_bank u_bank (
            .clk_sys_i   (clk_sys_i),
            .rst_b_i     (rst_b_i),
            .ld_we_i     (ld_take && tgt.port == 2'(p)),
            .ld_fld_i    (tgt.fld),
            .ld_hi_i     (tgt.hi),
            .ld_data_i   (word_i.data),
            .bus_we_i    (bus_fld_we && bus_port == 2'(p)),
            .bus_fld_i   (bus_fld),
            .bus_wdata_i (wdata_i),
            .cfg_o       (port_cfg_o[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load phase state.
    ////////////////////////////////////////////////////////////////////////////

    // The ready flag rises once on the end-of-load mark and stays.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_ready <= 1'b0;
        end else if (load_done_i) begin
            cfg_ready <= 1'b1;
        end
    end

    // Presence is caught during the load; after it the flag is frozen.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_seen <= 1'b0;
        end else if (!cfg_ready) begin
            mem_seen <= mem_present_i;
        end
    end

    // A failed read is remembered until the next reset.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_err <= 1'b0;
        end else if (word_valid_i && mem_present_i && !word_i.ok && !cfg_ready) begin
            word_err <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register.
    ////////////////////////////////////////////////////////////////////////////

    // Write protect freezes all port fields against software.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_prot <= 1'b0;
        end else if (wr_i && cfg_ready && addr_i == {2'h0, ecm_pkg::OFF_CTRL}) begin
            wr_prot <= wdata_i[ecm_pkg::CTRL_WP];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////////////////

    // Reads before the load ends and unmapped reads return zero; the
    // slave never stalls, so this is the only way to refuse.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!cfg_ready) begin
            next_rdata = 32'h0000_0000;
        end else if (addr_i == {2'h0, ecm_pkg::OFF_CTRL}) begin
            next_rdata[ecm_pkg::CTRL_WP] = wr_prot;
        end else if (addr_i == {2'h0, ecm_pkg::OFF_STAT}) begin
            next_rdata[ecm_pkg::STAT_DONE] = cfg_ready;
            next_rdata[ecm_pkg::STAT_PRES] = mem_seen;
            next_rdata[ecm_pkg::STAT_ERR]  = word_err;
        end else begin
            case (bus_fld)
                ecm_pkg::FLD_SLOT:  next_rdata = port_cfg_o[bus_port].slot_cap;
                ecm_pkg::FLD_VCTS:  next_rdata[ecm_pkg::VCTS_LSB +: 7] = port_cfg_o[bus_port].vc1_ts;
                ecm_pkg::FLD_TCVC:  next_rdata[7:0] = port_cfg_o[bus_port].tc_map;
                ecm_pkg::FLD_MISC0: next_rdata = port_cfg_o[bus_port].misc0;
                ecm_pkg::FLD_MISC1: next_rdata = port_cfg_o[bus_port].misc1;
                default:            next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////

    // Slot word 94h goes to port 2, 96h to port 3.
    AST_SLOT_LO_P2: assert property (
        ld_take && word_i.addr == 8'h94 |=> port_cfg_o[2].slot_cap[15:0] == $past(word_i.data))
        else $error("slot low word of port 2 not loaded");
    AST_SLOT_LO_P3: assert property (
        ld_take && word_i.addr == 8'h96 |=> port_cfg_o[3].slot_cap[15:0] == $past(word_i.data))
        else $error("slot low word of port 3 not loaded");

    // High slot words keep the low half intact.
    AST_SLOT_HI: assert property (
        ld_take && word_i.addr == 8'h9C |=> port_cfg_o[2].slot_cap ==
        {$past(word_i.data), $past(port_cfg_o[2].slot_cap[15:0])})
        else $error("slot high word of port 2 wrong");

    // The first high slot word belongs to port 1, not port 0.
    AST_SLOT_HI_P1: assert property (
        ld_take && word_i.addr == 8'h9A |=> port_cfg_o[1].slot_cap[31:16] == $past(word_i.data))
        else $error("slot high word of port 1 wrong");

    // The last high slot word belongs to port 3.
    AST_SLOT_HI_P3: assert property (
        ld_take && word_i.addr == 8'h9E |=> port_cfg_o[3].slot_cap[31:16] == $past(word_i.data))
        else $error("slot high word of port 3 wrong");

    // Time slot field takes the low seven bits.
    AST_VC1_TS: assert property (
        ld_take && word_i.addr == 8'hA6 |=> port_cfg_o[3].vc1_ts == $past(word_i.data[6:0]))
        else $error("time slot of port 3 wrong");

    // The first time slot word belongs to port 0.
    AST_VC1_TS_P0: assert property (
        ld_take && word_i.addr == 8'hA0 |=> port_cfg_o[0].vc1_ts == $past(word_i.data[6:0]))
        else $error("time slot of port 0 wrong");

    // Class map takes the high byte of the same word.
    AST_TC_MAP: assert property (
        ld_take && word_i.addr == 8'hA0 |=> port_cfg_o[0].tc_map == $past(word_i.data[15:8]))
        else $error("class map of port 0 wrong");

    // Class map of port 2 comes from word A4h.
    AST_TC_MAP_P2: assert property (
        ld_take && word_i.addr == 8'hA4 |=> port_cfg_o[2].tc_map == $past(word_i.data[15:8]))
        else $error("class map of port 2 wrong");

    // Misc control 0 halves, ports 1 and 3.
    AST_MISC0_LO: assert property (
        ld_take && word_i.addr == 8'hB2 |=> port_cfg_o[1].misc0[15:0] == $past(word_i.data))
        else $error("misc 0 low of port 1 wrong");
    AST_MISC0_HI: assert property (
        ld_take && word_i.addr == 8'hBE |=> port_cfg_o[3].misc0[31:16] == $past(word_i.data))
        else $error("misc 0 high of port 3 wrong");

    // A low misc word must leave the high half of port 0 alone.
    AST_MISC0_LO_P0: assert property (
        ld_take && word_i.addr == 8'hB0 |=> port_cfg_o[0].misc0 ==
        {$past(port_cfg_o[0].misc0[31:16]), $past(word_i.data)})
        else $error("misc 0 low of port 0 wrong");

    // High misc word of port 0 comes from B8h.
    AST_MISC0_HI_P0: assert property (
        ld_take && word_i.addr == 8'hB8 |=> port_cfg_o[0].misc0[31:16] == $past(word_i.data))
        else $error("misc 0 high of port 0 wrong");

    // Misc control 1 low of port 0.
    AST_MISC1_LO: assert property (
        ld_take && word_i.addr == 8'hC0 |=> port_cfg_o[0].misc1[15:0] == $past(word_i.data))
        else $error("misc 1 low of port 0 wrong");

    // Word 92h lands in port 1.
    AST_SLOT_LO_P1: assert property (
        ld_take && word_i.addr == 8'h92 |=> port_cfg_o[1].slot_cap[15:0] == $past(word_i.data))
        else $error("slot low word of port 1 not loaded");

    // A failed or absent read leaves every field untouched.
    AST_BAD_WORD: assert property (
        word_valid_i && (!word_i.ok || !mem_present_i) && !wr_i |=> $stable(port_cfg_o))
        else $error("field changed on a bad word");

    // Reads before load end return zero, and data never linger.
    AST_RD_EARLY: assert property (
        (rd_i && !cfg_ready) or !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    // Once the load is over it stays over until reset.
    AST_READY_STAYS: assert property (
        cfg_ready |=> cfg_ready)
        else $error("load finished flag dropped");

    // Words that arrive after the load must not disturb software's values.
    AST_LATE_WORD: assert property (
        word_valid_i && cfg_ready && !wr_i |=> $stable(port_cfg_o))
        else $error("field changed on a word after the load");

    // Software writes are refused while the load is still open.
    AST_SW_EARLY: assert property (
        wr_i && !cfg_ready && !word_valid_i |=> $stable(port_cfg_o))
        else $error("field changed on an early software write");

    // Write protect freezes every port field.
    AST_WP_HOLD: assert property (
        wr_i && wr_prot |=> $stable(port_cfg_o))
        else $error("field changed under write protect");

endmodule : ecm_config_mapper
`default_nettype wire

//--- hdl/ecm_pkg.sv
// Shared constants and types for the configuration word mapper.
package ecm_pkg;

    // Number of switch ports served.
    localparam int NPORT = 4;

    // Memory word addresses that start each run of per-port words.
    localparam logic [7:0] MA_SLOT_LO  = 8'h92;
    localparam logic [7:0] MA_SLOT_HI  = 8'h9A;
    localparam logic [7:0] MA_VC       = 8'hA0;
    localparam logic [7:0] MA_MISC0_LO = 8'hB0;
    localparam logic [7:0] MA_MISC0_HI = 8'hB8;
    localparam logic [7:0] MA_MISC1_LO = 8'hC0;

    // Configuration offsets inside one port's space.
    localparam logic [11:0] OFF_SLOT  = 12'hD4;
    localparam logic [11:0] OFF_VCTS  = 12'h15C;
    localparam logic [11:0] OFF_TCVC  = 12'h160;
    localparam logic [11:0] OFF_MISC0 = 12'h300;
    localparam logic [11:0] OFF_MISC1 = 12'h304;
    localparam logic [11:0] OFF_CTRL  = 12'h400;
    localparam logic [11:0] OFF_STAT  = 12'h404;

    // Field positions.
    localparam int VCTS_LSB   = 16;
    localparam int TCMAP_SRC  = 8;
    localparam int CTRL_WP    = 0;
    localparam int STAT_DONE  = 0;
    localparam int STAT_PRES  = 1;
    localparam int STAT_ERR   = 2;

    // Values after reset.
    localparam logic [31:0] DEF_SLOT  = 32'h0000_0000;
    localparam logic [6:0]  DEF_VCTS  = 7'h7F;
    localparam logic [7:0]  DEF_TCMAP = 8'h00;
    localparam logic [31:0] DEF_MISC  = 32'h0000_0000;

    // Target field of a word or of a bus access.
    typedef enum logic [2:0] {FLD_NONE, FLD_SLOT, FLD_VCTS, FLD_TCVC, FLD_MISC0, FLD_MISC1} ecm_fld_e;

    // One word delivered by the memory read engine.
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
        logic        ok;
    } ecm_word_s;

    // Where a memory word lands.
    typedef struct packed {
        logic       hit;
        logic [1:0] port;
        ecm_fld_e   fld;
        logic       hi;
    } ecm_tgt_s;

    // Configuration fields of one port.
    typedef struct packed {
        logic [31:0] slot_cap;
        logic [6:0]  vc1_ts;
        logic [7:0]  tc_map;
        logic [31:0] misc0;
        logic [31:0] misc1;
    } ecm_port_cfg_s;

endpackage : ecm_pkg

//--- hdl/ecm_word_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Maps a memory word address onto a port, a field and a half.
module ecm_word_decode (
    // Word address.
    input  wire logic [7:0]     addr_i,
    // Decoded target.
    output ecm_pkg::ecm_tgt_s   tgt_o
);

    // True when the address falls on one of n even words from base.
    function automatic logic in_run(input logic [7:0] a, input logic [7:0] b, input logic [2:0] n);
        logic [7:0] d;
        d = a - b;
        in_run = (a >= b) && !a[0] && (d[7:1] < {4'h0, n});
    endfunction : in_run

    // Port index within a run.
    function automatic logic [1:0] idx(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        idx = d[2:1];
    endfunction : idx

    // Slot words start at port 1, so their index is bumped by one.
    always_comb begin
        tgt_o = '{hit: 1'b0, port: 2'h0, fld: ecm_pkg::FLD_NONE, hi: 1'b0};
        if (in_run(addr_i, ecm_pkg::MA_SLOT_LO, 3'h3)) begin
            tgt_o = '{1'b1, 2'(idx(addr_i, ecm_pkg::MA_SLOT_LO) + 2'h1), ecm_pkg::FLD_SLOT, 1'b0};
        end else if (in_run(addr_i, ecm_pkg::MA_SLOT_HI, 3'h3)) begin
            tgt_o = '{1'b1, 2'(idx(addr_i, ecm_pkg::MA_SLOT_HI) + 2'h1), ecm_pkg::FLD_SLOT, 1'b1};
        end else if (in_run(addr_i, ecm_pkg::MA_VC, 3'h4)) begin
            tgt_o = '{1'b1, idx(addr_i, ecm_pkg::MA_VC), ecm_pkg::FLD_VCTS, 1'b0};
        end else if (in_run(addr_i, ecm_pkg::MA_MISC0_LO, 3'h4)) begin
            tgt_o = '{1'b1, idx(addr_i, ecm_pkg::MA_MISC0_LO), ecm_pkg::FLD_MISC0, 1'b0};
        end else if (in_run(addr_i, ecm_pkg::MA_MISC0_HI, 3'h4)) begin
            tgt_o = '{1'b1, idx(addr_i, ecm_pkg::MA_MISC0_HI), ecm_pkg::FLD_MISC0, 1'b1};
        end else if (addr_i == ecm_pkg::MA_MISC1_LO) begin
            tgt_o = '{1'b1, 2'h0, ecm_pkg::FLD_MISC1, 1'b0};
        end
    end

endmodule : ecm_word_decode
`default_nettype wire

//--- hdl/ecm_port_bank.sv
`timescale 1ns/10ps
`default_nettype none
// Configuration fields of one port, loaded from memory words or written by software.
module ecm_port_bank (
    // Clock and reset.
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    // Load side.
    input  wire logic                   ld_we_i,
    input  wire ecm_pkg::ecm_fld_e      ld_fld_i,
    input  wire logic                   ld_hi_i,
    input  wire logic [15:0]            ld_data_i,
    // Software side.
    input  wire logic                   bus_we_i,
    input  wire ecm_pkg::ecm_fld_e      bus_fld_i,
    input  wire logic [31:0]            bus_wdata_i,
    // Field values.
    output ecm_pkg::ecm_port_cfg_s      cfg_o
);

    // Puts a 16-bit word into one half of a 32-bit field.
    function automatic logic [31:0] put16(input logic [31:0] old, input logic hi, input logic [15:0] w);
        put16 = hi ? {w, old[15:0]} : {old[31:16], w};
    endfunction : put16

    // Load wins over software, though the top never lets both meet.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_o.slot_cap <= ecm_pkg::DEF_SLOT;
        end else if (ld_we_i && ld_fld_i == ecm_pkg::FLD_SLOT) begin
            cfg_o.slot_cap <= put16(cfg_o.slot_cap, ld_hi_i, ld_data_i);
        end else if (bus_we_i && bus_fld_i == ecm_pkg::FLD_SLOT) begin
            cfg_o.slot_cap <= bus_wdata_i;
        end
    end

    // One word feeds both the time slot limit and the class map.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_o.vc1_ts <= ecm_pkg::DEF_VCTS;
            cfg_o.tc_map <= ecm_pkg::DEF_TCMAP;
        end else if (ld_we_i && ld_fld_i == ecm_pkg::FLD_VCTS) begin
            cfg_o.vc1_ts <= ld_data_i[6:0];
            cfg_o.tc_map <= ld_data_i[ecm_pkg::TCMAP_SRC +: 8];
        end else if (bus_we_i && bus_fld_i == ecm_pkg::FLD_VCTS) begin
            cfg_o.vc1_ts <= bus_wdata_i[ecm_pkg::VCTS_LSB +: 7];
        end else if (bus_we_i && bus_fld_i == ecm_pkg::FLD_TCVC) begin
            cfg_o.tc_map <= bus_wdata_i[7:0];
        end
    end

    // Miscellaneous control 0.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_o.misc0 <= ecm_pkg::DEF_MISC;
        end else if (ld_we_i && ld_fld_i == ecm_pkg::FLD_MISC0) begin
            cfg_o.misc0 <= put16(cfg_o.misc0, ld_hi_i, ld_data_i);
        end else if (bus_we_i && bus_fld_i == ecm_pkg::FLD_MISC0) begin
            cfg_o.misc0 <= bus_wdata_i;
        end
    end

    // Miscellaneous control 1.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_o.misc1 <= ecm_pkg::DEF_MISC;
        end else if (ld_we_i && ld_fld_i == ecm_pkg::FLD_MISC1) begin
            cfg_o.misc1 <= put16(cfg_o.misc1, ld_hi_i, ld_data_i);
        end else if (bus_we_i && bus_fld_i == ecm_pkg::FLD_MISC1) begin
            cfg_o.misc1 <= bus_wdata_i;
        end
    end

endmodule : ecm_port_bank
`default_nettype wire

//--- bench/ecm_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the configuration memory and its read engine.
module ecm_mem_model (
    // Clock and reset.
    input  wire logic          clk_sys_i,
    input  wire logic          rst_b_i,
    // Control from the bench.
    input  wire logic          start_i,
    input  wire logic [3:0]    gap_i,
    input  wire logic [7:0]    bad_addr_i,
    // Word stream.
    output logic               word_valid_o,
    output ecm_pkg::ecm_word_s word_o,
    output logic               load_done_o
);
    // Word contents, indexed by byte address over two.
    logic [15:0] mem [0:127];

    ////////////////////////////////////////////////////////////////
    // Walks 90h to C2h in order, so unmapped words are sent too.
    // Data in the gaps between words (gap_i not zero) are inverted so a stale word never looks valid.
    initial begin
        word_valid_o = 1'b0;
        word_o = '0;
        load_done_o = 1'b0;
        forever begin
            @(posedge clk_sys_i);
            if (start_i && rst_b_i) begin
                for (int a = 8'h90; a <= 8'hC2; a += 2) begin
                    word_valid_o <= 1'b1;
                    word_o <= '{a[7:0], mem[a[7:1]], (a[7:0] != bad_addr_i)};
                    @(posedge clk_sys_i);
                    if (gap_i != 4'h0) begin
                        word_valid_o <= 1'b0;
                        word_o.data <= ~word_o.data;
                        repeat (gap_i) @(posedge clk_sys_i);
                    end
                end
                word_valid_o <= 1'b0;
                load_done_o <= 1'b1;
                @(posedge clk_sys_i);
                load_done_o <= 1'b0;
            end
        end
    end
endmodule : ecm_mem_model
`default_nettype wire

//--- bench/tb_ecm_config_mapper.sv
`timescale 1ns/10ps
`default_nettype none
// Loads words from the memory model and compares every field with a bench model.
module tb_ecm_config_mapper;
    logic clk_sys_i, rst_b_i, word_valid_i, mem_present_i, load_done_i;
    logic wr_i, rd_i, start;
    logic [13:0] addr_i;
    logic [31:0] wdata_i, rdata_o, r, w;
    logic [3:0] gap;
    logic [7:0] bad;
    ecm_pkg::ecm_word_s word_i;
    ecm_pkg::ecm_port_cfg_s [3:0] port_cfg_o;
    logic cfg_ready_o;
    int miscompares, check_count;
    // Expected field values per port.
    logic [31:0] e_slot [4], e_vc [4], e_tc [4], e_m0 [4], e_m1 [4];

    ecm_config_mapper u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .word_valid_i(word_valid_i),
        .word_i(word_i), .mem_present_i(mem_present_i), .load_done_i(load_done_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_cfg_o(port_cfg_o),
        .cfg_ready_o(cfg_ready_o));
    ecm_mem_model u_mem (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(start), .gap_i(gap),
        .bad_addr_i(bad), .word_valid_o(word_valid_i), .word_o(word_i), .load_done_o(load_done_i));

    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic print_verdict();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end
        else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bus tasks are entered just after a rising edge.
    task automatic wr(input logic [1:0] p, input logic [11:0] off, input logic [31:0] d);
        wr_i <= 1'b1;
        addr_i <= {p, off};
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        // One idle edge, so a following write never re-raises the strobe in the same step.
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [1:0] p, input logic [11:0] off, output logic [31:0] d);
        rd_i <= 1'b1;
        addr_i <= {p, off};
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        // Data stand in the cycle after the strobe; take them at the edge that closes it.
        @(posedge clk_sys_i);
        d = rdata_o;
    endtask : rd

    // Bench model of where each memory word lands.
    task automatic apply(input logic [7:0] a, input logic [15:0] v);
        if (a >= 8'h92 && a <= 8'h96) e_slot[(a - 8'h90) >> 1][15:0] = v;
        else if (a >= 8'h9A && a <= 8'h9E) e_slot[(a - 8'h98) >> 1][31:16] = v;
        else if (a >= 8'hA0 && a <= 8'hA6) begin
            e_vc[(a - 8'hA0) >> 1] = {25'h0, v[6:0]};
            e_tc[(a - 8'hA0) >> 1] = {24'h0, v[15:8]};
        end
        else if (a >= 8'hB0 && a <= 8'hB6) e_m0[(a - 8'hB0) >> 1][15:0] = v;
        else if (a >= 8'hB8 && a <= 8'hBE) e_m0[(a - 8'hB8) >> 1][31:16] = v;
        else if (a == 8'hC0) e_m1[0][15:0] = v;
    endtask : apply

    // Compares port outputs, and register reads once loading is over.
    task automatic chk_all();
        logic [31:0] e [5];
        logic [11:0] o [5];
        o = '{ecm_pkg::OFF_SLOT, ecm_pkg::OFF_VCTS, ecm_pkg::OFF_TCVC, ecm_pkg::OFF_MISC0, ecm_pkg::OFF_MISC1};
        for (int p = 0; p < 4; p++) begin
            chk(port_cfg_o[p].slot_cap, e_slot[p]);
            chk({25'h0, port_cfg_o[p].vc1_ts}, e_vc[p]);
            chk({24'h0, port_cfg_o[p].tc_map}, e_tc[p]);
            chk(port_cfg_o[p].misc0, e_m0[p]);
            chk(port_cfg_o[p].misc1, e_m1[p]);
            e = '{e_slot[p], e_vc[p] << 16, e_tc[p], e_m0[p], e_m1[p]};
            for (int k = 0; k < 5 && cfg_ready_o === 1'b1; k++) begin
                rd(p[1:0], o[k], r);
                chk(r, e[k]);
            end
        end
    endtask : chk_all

    task automatic run_load();
        @(posedge clk_sys_i);
        start <= 1'b1;
        @(posedge clk_sys_i);
        start <= 1'b0;
        for (int i = 0; i < 400 && load_done_i !== 1'b1; i++) @(posedge clk_sys_i);
        repeat (2) @(posedge clk_sys_i);
    endtask : run_load

    ////////////////////////////////////////////////////////////////
    // Pass 0: memory absent, slow stream. Pass 1: present, back to back, one bad word.
    initial begin
        {rst_b_i, mem_present_i, wr_i, rd_i, start, addr_i, wdata_i, gap, bad} = '0;
        void'($urandom(69105));
        for (int pass = 0; pass < 2; pass++) begin
            mem_present_i <= pass[0];
            gap <= pass[0] ? 4'h0 : 4'h3;
            bad <= 8'h90 + 8'($urandom_range(24, 1) * 2);
            for (int i = 0; i < 128; i++) u_mem.mem[i] = 16'($urandom);
            rst_b_i <= 1'b0;
            repeat (16) @(posedge clk_sys_i);
            rst_b_i <= 1'b1;
            @(posedge clk_sys_i);
            for (int p = 0; p < 4; p++) {e_slot[p], e_vc[p], e_tc[p], e_m0[p], e_m1[p]} = {32'h0, 32'h7F, 96'h0};
            chk_all();
            rd(2'h1, ecm_pkg::OFF_MISC0, r);
            chk(r, 32'h0);
            wr(2'h1, ecm_pkg::OFF_MISC0, 32'hFFFF_FFFF);
            run_load();
            for (int a = 8'h90; a <= 8'hC2 && pass == 1; a += 2) if (a[7:0] != bad) apply(a[7:0], u_mem.mem[a >> 1]);
            chk({31'h0, cfg_ready_o}, 32'h1);
            chk_all();
            rd(2'h0, ecm_pkg::OFF_STAT, r);
            chk(r, {29'h0, pass[0], pass[0], 1'b1});
        end
        w = $urandom;
        wr(2'h2, ecm_pkg::OFF_MISC1, w);
        e_m1[2] = w;
        wr(2'h3, 12'h0F0, 32'hFFFF_FFFF);
        rd(2'h3, 12'h0F0, r);
        chk(r, 32'h0);
        for (int i = 0; i < 128; i++) u_mem.mem[i] = 16'($urandom);
        run_load();
        chk_all();
        // Write protect on: a slot write to port 1 must not land.
        wr(2'h0, ecm_pkg::OFF_CTRL, 32'h1);
        wr(2'h1, ecm_pkg::OFF_SLOT, ~e_slot[1]);
        rd(2'h0, ecm_pkg::OFF_CTRL, r);
        chk(r, 32'h1);
        chk(port_cfg_o[1].slot_cap, e_slot[1]);
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the passes need.
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        miscompares++;
        print_verdict();
    end
endmodule : tb_ecm_config_mapper
`default_nettype wire
